// ===== src/swr_router.v
/*
 * Path and channel router for one port of a serial web node: decodes
 * the route byte and channel selector of inbound frames, keeps per-link
 * acknowledge and receiver-ready handling, and holds its registers.
 * Assumes address bytes arrive from same-clock receive logic, one per
 * addr_valid cycle, with addr_first on the first route byte.
 */
// Overview of operation
// - single port accepts 00h, else reject
// - single port reports port number one
// - dual port decrements nonzero index, forwards
// - dual port rejects 80h
// - dual port reports port one or two
// - switch port count even, 4 to 126
// - switch accepts 00h, decodes channel selector
// - index within ports: forward there, delete byte
// - index beyond ports: forward to pair partner
// - paired scheme subtracts ports plus one
// - switch rejects 80h
// - switch rejects delete with no continuation
// - switch rejects routing back to input
// - switch ports numbered from one
// - channel index 0 selects control message
// - single channel byte selects that channel
// - two bytes select 128 times first plus second
// - malformed channel starts frame-reject recovery
// - pairs are two adjacent identical specials
// - pairs never cross between ports
// - pending pairs may interleave mid-frame
// - indexes are unsigned seven bits
// - forwarded frames get a fresh check field
`timescale 1ns/100ps
`default_nettype none
`include "swr_consts.vh"

module swr_router (
    input wire ref_clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire addr_valid,
    input wire addr_first,
    input wire [7:0] addr_byte,
    output reg dec_valid,
    output reg [1:0] dec_action,
    output reg [6:0] dec_out_port,
    output reg [7:0] dec_new_byte,
    output reg dec_delete,
    output reg dec_crc_regen,
    output reg ch_valid,
    output reg [13:0] ch_number,
    output reg ch_control_message,
    output reg link_error_recovery,
    output reg [3:0] link_error_code,
    input wire rx_valid,
    input wire [1:0] rx_spc,
    input wire ack_req,
    input wire rr_req,
    output wire ack_pair,
    output wire rr_pair,
    output wire pair_single_err,
    input wire frm_valid,
    input wire frm_in_frame,
    input wire [7:0] frm_char,
    output wire frm_ready,
    output wire tx_valid,
    output wire [7:0] tx_char,
    output wire [1:0] tx_spc
);
    // --
    // Decode states
    // --
    localparam [1:0] ST_PATH = 2'h0;
    localparam [1:0] ST_CH1 = 2'h1;
    localparam [1:0] ST_CH2 = 2'h2;
    localparam [1:0] ST_SKIP = 2'h3;

    reg [2:0] ctrl_reg;
    reg [6:0] ports_reg;
    reg [6:0] portnum_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [6:0] ch1_reg;
    reg ack_pend_reg;
    reg rr_pend_reg;
    reg [15:0] rejcnt_reg;
    reg [15:0] last_reg;
    reg [1:0] act;
    reg [6:0] oport;
    reg [7:0] nbyte;
    reg del;
    reg rej;
    reg [7:0] rdata_next;

    wire [1:0] node_type;
    wire full_duplex;
    wire [6:0] port_eff;
    wire ack_sent;
    wire rr_sent;

    assign node_type = ctrl_reg[`SWR_CTRL_TYPE_LSB + 1:`SWR_CTRL_TYPE_LSB];
    assign full_duplex = ctrl_reg[`SWR_CTRL_FDX_BIT];

    // --
    // Byte field helpers
    // --
    // continuation in bit 7
    function ext_of;
        input [7:0] b;
        begin
            ext_of = b[`SWR_EXT_BIT];
        end
    endfunction

    function [6:0] idx_of;
        input [7:0] b;
        begin
            idx_of = b[6:0];
        end
    endfunction

    function [6:0] clamp_ports;
        input [6:0] p;
        reg [6:0] e;
        begin
            e = {p[6:1], 1'b0};
            if (e < `SWR_PORTS_MIN) begin
                clamp_ports = `SWR_PORTS_MIN;
            end else if (e > `SWR_PORTS_MAX) begin
                clamp_ports = `SWR_PORTS_MAX;
            end else begin
                clamp_ports = e;
            end
        end
    endfunction

    // --
    // Reported port number
    // --
    // single port is one
    // dual port is one or two
    function [6:0] port_of;
        input [1:0] t;
        input [6:0] req;
        input [6:0] np;
        begin
            case (t)
                `SWR_NODE_DUAL: port_of = (req == 7'h02) ? 7'h02 : 7'h01;
                `SWR_NODE_SWITCH: port_of = (req == 7'h00) ? 7'h01 :
                    ((req > np) ? np : req);
                default: port_of = 7'h01;
            endcase
        end
    endfunction

    assign port_eff = port_of(node_type, portnum_reg, ports_reg);

    // --
    // Route byte decision
    // --
    always @* begin
        act = `SWR_ACT_REJECT;
        oport = 7'h00;
        nbyte = addr_byte;
        del = 1'b0;
        if (addr_byte == `SWR_SELF_BYTE) begin
            act = `SWR_ACT_ACCEPT;
        end else begin
            case (node_type)
                `SWR_NODE_DUAL: begin
                    if (idx_of(addr_byte) != 7'h00) begin
                        act = `SWR_ACT_FORWARD;
                        oport = (port_eff == 7'h01) ? 7'h02 : 7'h01;
                        nbyte = {ext_of(addr_byte), idx_of(addr_byte) - 7'h01};
                    end
                end
                `SWR_NODE_SWITCH: begin
                    if (idx_of(addr_byte) > ports_reg) begin
                        act = `SWR_ACT_FORWARD;
                        oport = port_eff[0] ? port_eff + 7'h01 : port_eff - 7'h01;
                        nbyte = {ext_of(addr_byte),
                            idx_of(addr_byte) - ports_reg - 7'h01};
                    end else if (idx_of(addr_byte) != 7'h00 &&
                            idx_of(addr_byte) != port_eff &&
                            ext_of(addr_byte)) begin
                        // out the named port, byte removed
                        act = `SWR_ACT_FORWARD;
                        oport = idx_of(addr_byte);
                        del = 1'b1;
                    end
                end
                default: begin
                    act = `SWR_ACT_REJECT;
                end
            endcase
        end
        rej = (act == `SWR_ACT_REJECT);
    end

    // --
    // Address byte sequencer
    // --
    always @* begin
        state_next = state_reg;
        if (addr_valid) begin
            if (addr_first) begin
                state_next = (act == `SWR_ACT_ACCEPT) ? ST_CH1 : ST_SKIP;
            end else begin
                case (state_reg)
                    ST_CH1: state_next = (idx_of(addr_byte) != 7'h00 &&
                        ext_of(addr_byte)) ? ST_CH2 : ST_SKIP;
                    ST_CH2: state_next = ST_SKIP;
                    default: state_next = state_reg;
                endcase
            end
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_SKIP;
            ch1_reg <= 7'h00;
            dec_valid <= 1'b0;
            dec_action <= `SWR_ACT_ACCEPT;
            dec_out_port <= 7'h00;
            dec_new_byte <= 8'h00;
            dec_delete <= 1'b0;
            dec_crc_regen <= 1'b0;
            ch_valid <= 1'b0;
            ch_number <= 14'h0000;
            ch_control_message <= 1'b0;
            link_error_recovery <= 1'b0;
            link_error_code <= 4'h0;
        end else begin
            state_reg <= state_next;
            dec_valid <= 1'b0;
            ch_valid <= 1'b0;
            link_error_recovery <= 1'b0;
            if (addr_valid && addr_first) begin
                dec_valid <= 1'b1;
                dec_action <= act;
                dec_out_port <= oport;
                dec_new_byte <= nbyte;
                dec_delete <= del;
                dec_crc_regen <= (act == `SWR_ACT_FORWARD);
                if (rej) begin
                    link_error_recovery <= 1'b1;
                    link_error_code <= `SWR_ERR_FRAME_REJECT;
                end
            end else if (addr_valid && state_reg == ST_CH1) begin
                ch1_reg <= idx_of(addr_byte);
                if (idx_of(addr_byte) == 7'h00) begin
                    if (ext_of(addr_byte)) begin
                        link_error_recovery <= 1'b1;
                        link_error_code <= `SWR_ERR_FRAME_REJECT;
                    end else begin
                        ch_valid <= 1'b1;
                        ch_number <= 14'h0000;
                        ch_control_message <= 1'b1;
                    end
                end else if (!ext_of(addr_byte)) begin
                    ch_valid <= 1'b1;
                    ch_number <= {7'h00, idx_of(addr_byte)};
                    ch_control_message <= 1'b0;
                end
            end else if (addr_valid && state_reg == ST_CH2) begin
                if (!ext_of(addr_byte)) begin
                    ch_valid <= 1'b1;
                    ch_number <= {ch1_reg, idx_of(addr_byte)};
                    ch_control_message <= 1'b0;
                end else begin
                    link_error_recovery <= 1'b1;
                    link_error_code <= `SWR_ERR_FRAME_REJECT;
                end
            end
        end
    end

    // --
    // Per-link flow control
    // --
    // pairs end here, never relayed
    swr_pair_det u_pair (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rx_valid(rx_valid),
        .rx_spc(rx_spc),
        .ack_pair(ack_pair),
        .rr_pair(rr_pair),
        .single_err(pair_single_err)
    );

    // Set wins over the clear so a request in the send cycle is kept
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_pend_reg <= 1'b0;
            rr_pend_reg <= 1'b0;
        end else begin
            ack_pend_reg <= ack_req | (ack_pend_reg & ~ack_sent);
            rr_pend_reg <= rr_req | (rr_pend_reg & ~rr_sent);
        end
    end

    swr_tx_ins u_tx (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .full_duplex(full_duplex),
        .ack_pend(ack_pend_reg),
        .rr_pend(rr_pend_reg),
        .frm_valid(frm_valid),
        .frm_in_frame(frm_in_frame),
        .frm_char(frm_char),
        .frm_ready(frm_ready),
        .tx_valid(tx_valid),
        .tx_char(tx_char),
        .tx_spc(tx_spc),
        .ack_sent(ack_sent),
        .rr_sent(rr_sent)
    );

    // --
    // Registers
    // --
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `SWR_CTRL_RST;
            ports_reg <= `SWR_PORTS_RST;
            portnum_reg <= `SWR_PORTNUM_RST;
            rejcnt_reg <= 16'h0000;
            last_reg <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `SWR_OFF_CTRL) begin
                ctrl_reg <= reg_wdata[2:0];
            end
            if (reg_wr && reg_addr == `SWR_OFF_PORTS) begin
                ports_reg <= clamp_ports(reg_wdata[6:0]);
            end
            if (reg_wr && reg_addr == `SWR_OFF_PORTNUM) begin
                portnum_reg <= reg_wdata[6:0];
            end
            // Counter saturates; an increment in a clearing write wins
            if (addr_valid && addr_first && rej) begin
                if (rejcnt_reg != 16'hffff) begin
                    rejcnt_reg <= rejcnt_reg + 16'h0001;
                end
            end else if (reg_wr && reg_addr == `SWR_OFF_REJCNT) begin
                rejcnt_reg <= 16'h0000;
            end
            if (addr_valid && addr_first) begin
                last_reg <= {act, del, oport[4:0], nbyte};
            end
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SWR_OFF_CTRL: reg_rdata <= {29'h00000000, ctrl_reg};
                `SWR_OFF_PORTS: reg_rdata <= {25'h0000000, ports_reg};
                `SWR_OFF_PORTNUM: reg_rdata <= {25'h0000000, port_eff};
                `SWR_OFF_STATUS: reg_rdata <= {26'h0000000, state_reg,
                    ack_pend_reg, rr_pend_reg, node_type};
                `SWR_OFF_LAST: reg_rdata <= {16'h0000, last_reg};
                `SWR_OFF_REJCNT: reg_rdata <= {16'h0000, rejcnt_reg};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ===== src/swr_consts.vh
/*
 * Constants for the path and channel router: register offsets, field
 * positions, reset values and codes.
 * Assumes inclusion by bare name from the router design files.
 */
`ifndef SWR_CONSTS_VH
`define SWR_CONSTS_VH

// --
// Register offsets (byte addresses)
// --
`define SWR_OFF_CTRL 8'h00
`define SWR_OFF_PORTS 8'h04
`define SWR_OFF_PORTNUM 8'h08
`define SWR_OFF_STATUS 8'h0c
`define SWR_OFF_LAST 8'h10
`define SWR_OFF_REJCNT 8'h14

// --
// Field positions and reset values
// --
`define SWR_CTRL_TYPE_LSB 0
`define SWR_CTRL_FDX_BIT 2
`define SWR_CTRL_RST 3'h0
`define SWR_PORTS_RST 7'h04
`define SWR_PORTNUM_RST 7'h01
`define SWR_PORTS_MIN 7'h04
`define SWR_PORTS_MAX 7'h7e

// --
// Node types, route and channel byte layout
// --
`define SWR_NODE_SINGLE 2'h0
`define SWR_NODE_DUAL 2'h1
`define SWR_NODE_SWITCH 2'h2
`define SWR_EXT_BIT 7
`define SWR_SELF_BYTE 8'h00
`define SWR_SELF_EXT_BYTE 8'h80

// --
// Decisions, error code and special characters
// --
`define SWR_ACT_ACCEPT 2'h0
`define SWR_ACT_FORWARD 2'h1
`define SWR_ACT_REJECT 2'h2
`define SWR_ERR_FRAME_REJECT 4'h9
`define SWR_SPC_NONE 2'h0
`define SWR_SPC_ACK 2'h1
`define SWR_SPC_RR 2'h2

`endif

// ===== src/swr_pair_det.v
/*
 * Receive-side pair detector for acknowledge and receiver-ready
 * special characters on one link.
 * Assumes one received character per rx_valid cycle, same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swr_consts.vh"

module swr_pair_det (
    input wire ref_clk,
    input wire rst_n,
    input wire rx_valid,
    input wire [1:0] rx_spc,
    output reg ack_pair,
    output reg rr_pair,
    output reg single_err
);
    reg [1:0] prev_reg;

    // --
    // Pair matching
    // --
    // only back-to-back pairs
    // Any other character between the two breaks the pair; after a match
    // the slot is consumed so three in a row give one pair, not two.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= `SWR_SPC_NONE;
            ack_pair <= 1'b0;
            rr_pair <= 1'b0;
            single_err <= 1'b0;
        end else begin
            ack_pair <= 1'b0;
            rr_pair <= 1'b0;
            single_err <= 1'b0;
            if (rx_valid) begin
                if (rx_spc != `SWR_SPC_NONE && rx_spc == prev_reg) begin
                    ack_pair <= (rx_spc == `SWR_SPC_ACK);
                    rr_pair <= (rx_spc == `SWR_SPC_RR);
                    prev_reg <= `SWR_SPC_NONE;
                end else begin
                    single_err <= (prev_reg != `SWR_SPC_NONE);
                    prev_reg <= rx_spc;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/swr_tx_ins.v
/*
 * Transmit character selector: inserts pending acknowledge and
 * receiver-ready pairs ahead of frame characters.
 * Assumes one character slot per clock and a frame source that holds
 * its character until frm_ready.
 */
`timescale 1ns/100ps
`default_nettype none
`include "swr_consts.vh"

module swr_tx_ins (
    input wire ref_clk,
    input wire rst_n,
    input wire full_duplex,
    input wire ack_pend,
    input wire rr_pend,
    input wire frm_valid,
    input wire frm_in_frame,
    input wire [7:0] frm_char,
    output reg frm_ready,
    output reg tx_valid,
    output reg [7:0] tx_char,
    output reg [1:0] tx_spc,
    output reg ack_sent,
    output reg rr_sent
);
    reg [1:0] second_reg;
    wire ins_ok;
    wire [1:0] pick;

    // pairs may cut into a frame
    assign ins_ok = full_duplex | ~frm_in_frame;
    assign pick = ack_pend ? `SWR_SPC_ACK : (rr_pend ? `SWR_SPC_RR : `SWR_SPC_NONE);

    // --
    // Slot selection
    // --
    // frm_ready is registered, so the frame source sees it one slot late;
    // it is dropped for one slot only, at the first character; second_reg keeps the two characters adjacent.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            second_reg <= `SWR_SPC_NONE;
            frm_ready <= 1'b0;
            tx_valid <= 1'b0;
            tx_char <= 8'h00;
            tx_spc <= `SWR_SPC_NONE;
            ack_sent <= 1'b0;
            rr_sent <= 1'b0;
        end else begin
            ack_sent <= 1'b0;
            rr_sent <= 1'b0;
            if (second_reg != `SWR_SPC_NONE) begin
                tx_valid <= 1'b1;
                tx_spc <= second_reg;
                tx_char <= 8'h00;
                second_reg <= `SWR_SPC_NONE;
                frm_ready <= 1'b1;
            end else if (ins_ok && pick != `SWR_SPC_NONE) begin
                tx_valid <= 1'b1;
                tx_spc <= pick;
                tx_char <= 8'h00;
                second_reg <= pick;
                // Clear pending on the first character so one request sends one pair
                ack_sent <= (pick == `SWR_SPC_ACK);
                rr_sent <= (pick == `SWR_SPC_RR);
                frm_ready <= 1'b0;
            end else begin
                tx_valid <= frm_valid & frm_ready;
                tx_spc <= `SWR_SPC_NONE;
                tx_char <= frm_char;
                frm_ready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/swr_router_monitor.sv
/* Checker for the path and channel router, watching its ports only.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
`include "swr_consts.vh"
module swr_router_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic addr_valid,
    input wire logic addr_first,
    input wire logic dec_valid,
    input wire logic [1:0] dec_action,
    input wire logic dec_delete,
    input wire logic dec_crc_regen,
    input wire logic link_error_recovery,
    input wire logic [3:0] link_error_code,
    input wire logic rx_valid,
    input wire logic [1:0] rx_spc,
    input wire logic ack_pair,
    input wire logic rr_pair,
    input wire logic ack_req,
    input wire logic frm_valid,
    input wire logic frm_in_frame,
    input wire logic [1:0] tx_spc
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // --
    // Route, channel and pair relations
    // --
    a_reject_code: assert property (link_error_recovery |->
        link_error_code == `SWR_ERR_FRAME_REJECT) else $error("recovery code wrong");
    a_dec_cause: assert property (dec_valid |-> $past(addr_valid && addr_first))
        else $error("stray decision");
    a_crc_regen: assert property (dec_valid |->
        dec_crc_regen == (dec_action == `SWR_ACT_FORWARD)) else $error("check regen wrong");
    a_reject_erp: assert property (dec_valid && dec_action == `SWR_ACT_REJECT |->
        link_error_recovery) else $error("reject no erp");
    a_delete_fwd: assert property (dec_valid && dec_delete |->
        dec_action == `SWR_ACT_FORWARD) else $error("delete without forward");
    a_ack_pair: assert property (ack_pair |-> $past(rx_valid && rx_spc == 2'h1) &&
        $past(rx_valid && rx_spc == 2'h1, 2)) else $error("ack pair not adjacent");
    a_rr_pair: assert property (rr_pair |-> $past(rx_valid && rx_spc == 2'h2) &&
        $past(rx_valid && rx_spc == 2'h2, 2)) else $error("rr pair not adjacent");
    a_tx_pair: assert property (tx_spc != 2'h0 && $past(tx_spc) != tx_spc |=>
        tx_spc == $past(tx_spc)) else $error("lone special sent");
    // Only judged with no frame around, so half duplex cannot hold it off
    a_ack_insert: assert property (ack_req && !frm_valid && !frm_in_frame |->
        ##[2:6] tx_spc == `SWR_SPC_ACK) else $error("ack pair not sent");
    c_forward: cover property (dec_valid && dec_action == `SWR_ACT_FORWARD);
    c_ack: cover property (ack_pair);
    c_rr_tx: cover property (tx_spc == `SWR_SPC_RR);
endmodule
bind swr_router swr_router_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr_valid(addr_valid), .addr_first(addr_first), .dec_valid(dec_valid),
    .dec_action(dec_action), .dec_delete(dec_delete), .dec_crc_regen(dec_crc_regen),
    .link_error_recovery(link_error_recovery), .link_error_code(link_error_code),
    .rx_valid(rx_valid), .rx_spc(rx_spc), .ack_pair(ack_pair), .rr_pair(rr_pair),
    .ack_req(ack_req), .frm_valid(frm_valid), .frm_in_frame(frm_in_frame), .tx_spc(tx_spc));
`default_nettype wire

// ===== dv/swr_peer.sv
/* Neighbouring port across the link: sends special pairs, counts pairs.
   Assumes the router's transmit slot and receive inputs on one clock. */
`timescale 1ns/100ps
`default_nettype none
module swr_peer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] tx_spc,
    output var logic rx_valid,
    output var logic [1:0] rx_spc
);
    int seen[4];
    logic [1:0] last;
    initial begin
        rx_valid = 1'b0;
        rx_spc = 2'h0;
        last = 2'h0;
    end
    // only adjacent identical specials count as a pair
    always @(posedge ref_clk) begin
        if (rst_n && tx_spc != 2'h0 && tx_spc == last) begin
            seen[tx_spc]++;
            last <= 2'h0;
        end else begin
            last <= tx_spc;
        end
    end
    // two identical specials back to back
    task send_pair(input logic [1:0] s);
        repeat (2) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_spc <= s;
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        // Released line shows a different value, never the stale one
        rx_spc <= ~s;
    endtask
endmodule
`default_nettype wire

// ===== dv/swr_router_tb_top.sv
/* Bench for the router: registers, route and channel decode, pairs.
   Assumes swr_consts.vh on the include path and the peer model. */
`timescale 1ns/100ps
`default_nettype none
`include "swr_consts.vh"
module swr_router_tb_top;
    logic ref_clk, rst_n, reg_wr, reg_rd, addr_valid, addr_first, ack_req, rr_req;
    logic frm_valid, frm_in_frame;
    logic [7:0] reg_addr, addr_byte, frm_char;
    logic [31:0] reg_wdata;
    wire [31:0] reg_rdata;
    wire dec_valid, dec_delete, dec_crc_regen, ch_valid, ch_control_message;
    wire link_error_recovery, rx_valid, ack_pair, rr_pair, pair_single_err, frm_ready, tx_valid;
    wire [1:0] dec_action, rx_spc, tx_spc;
    wire [6:0] dec_out_port;
    wire [7:0] dec_new_byte, tx_char;
    wire [13:0] ch_number;
    wire [3:0] link_error_code;
    int miscompares, n_compared, n_ack, n_rr, n_err;
    swr_router DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .addr_valid, .addr_first, .addr_byte, .dec_valid, .dec_action, .dec_out_port,
        .dec_new_byte, .dec_delete, .dec_crc_regen, .ch_valid, .ch_number,
        .ch_control_message, .link_error_recovery, .link_error_code, .rx_valid, .rx_spc,
        .ack_req, .rr_req, .ack_pair, .rr_pair, .pair_single_err, .frm_valid,
        .frm_in_frame, .frm_char, .frm_ready, .tx_valid, .tx_char, .tx_spc);
    swr_peer PEER (.ref_clk, .rst_n, .tx_spc, .rx_valid, .rx_spc);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (ack_pair === 1'b1) n_ack++;
        if (rr_pair === 1'b1) n_rr++;
        if (pair_single_err !== 1'b0) n_err++;
    end
    // --
    // Access tasks
    // --
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask
    task byte_in(input logic f, input logic [7:0] b);
        @(posedge ref_clk);
        {addr_valid, addr_first, addr_byte} <= {1'b1, f, b};
        @(posedge ref_clk);
        addr_valid <= 1'b0;
        #1;
    endtask
    task route(input logic [7:0] b, input logic [1:0] act, input logic [6:0] port,
        input logic [7:0] nb, input logic del);
        byte_in(1'b1, b);
        chk("dv", dec_valid, 1);
        chk("act", dec_action, act);
        chk("erp", link_error_recovery, act == `SWR_ACT_REJECT);
        if (act == `SWR_ACT_FORWARD) begin
            chk("oport", dec_out_port, port);
            chk("del", dec_delete, del);
            if (!del) chk("nbyte", dec_new_byte, nb);
        end
    endtask
    task chan(input logic [7:0] b, input logic [13:0] num, input logic cm);
        byte_in(1'b0, b);
        chk("ch_valid", ch_valid, 1);
        chk("ch_number", ch_number, num);
        chk("ch_cm", ch_control_message, cm);
    endtask
    task final_report;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Whole run is about a hundred cycles; this is far beyond it
    initial begin
        #2000000;
        miscompares++;
        final_report;
    end
    initial begin
        {reg_wr, reg_rd, addr_valid, addr_first, ack_req, rr_req, frm_valid, frm_in_frame} = '0;
        {reg_addr, addr_byte, frm_char, reg_wdata} = '0;
        rst_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        wr(`SWR_OFF_PORTNUM, 2);
        rd(`SWR_OFF_PORTNUM, 1, "pn1");
        rd(8'h40, 0, "unmap");
        route(8'h00, `SWR_ACT_ACCEPT, 0, 0, 0);
        chan(8'h05, 5, 0);
        route(8'h00, `SWR_ACT_ACCEPT, 0, 0, 0);
        byte_in(1'b0, 8'h81);
        chan(8'h02, 14'd130, 0);
        route(8'h00, `SWR_ACT_ACCEPT, 0, 0, 0);
        chan(8'h00, 0, 1);
        route(8'h00, `SWR_ACT_ACCEPT, 0, 0, 0);
        byte_in(1'b0, 8'h80);
        chk("ch rej", link_error_recovery, 1);
        route(8'h01, `SWR_ACT_REJECT, 0, 0, 0);
        $display("test single done");
        wr(`SWR_OFF_CTRL, 1);
        rd(`SWR_OFF_PORTNUM, 2, "pn2");
        route(8'h03, `SWR_ACT_FORWARD, 1, 8'h02, 0);
        route(8'h80, `SWR_ACT_REJECT, 0, 0, 0);
        $display("test dual done");
        wr(`SWR_OFF_CTRL, 2);
        wr(`SWR_OFF_PORTS, 8'h7f);
        rd(`SWR_OFF_PORTS, 8'h7e, "pmax");
        wr(`SWR_OFF_PORTS, 2);
        rd(`SWR_OFF_PORTS, 4, "pmin");
        route(8'h00, `SWR_ACT_ACCEPT, 0, 0, 0);
        route(8'h81, `SWR_ACT_FORWARD, 1, 0, 1);
        route(8'h84, `SWR_ACT_FORWARD, 4, 0, 1);
        route(8'h05, `SWR_ACT_FORWARD, 1, 8'h00, 0);
        route(8'h87, `SWR_ACT_FORWARD, 1, 8'h82, 0);
        route(8'h03, `SWR_ACT_REJECT, 0, 0, 0);
        route(8'h82, `SWR_ACT_REJECT, 0, 0, 0);
        route(8'h80, `SWR_ACT_REJECT, 0, 0, 0);
        $display("test switch done");
        PEER.send_pair(`SWR_SPC_ACK);
        PEER.send_pair(`SWR_SPC_RR);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("ack_pair", n_ack, 1);
        chk("rr_pair", n_rr, 1);
        chk("rr relay", PEER.seen[2], 0);
        wr(`SWR_OFF_CTRL, 4);
        {frm_valid, frm_in_frame, frm_char} <= {2'b11, 8'h5a};
        @(posedge ref_clk);
        {ack_req, rr_req} <= 2'b11;
        @(posedge ref_clk);
        {ack_req, rr_req} <= 2'b00;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("ack fdx", PEER.seen[1], 1);
        chk("rr fdx", PEER.seen[2], 1);
        chk("tx frame", {tx_valid, frm_ready, tx_char}, 10'h35a);
        {frm_valid, frm_in_frame} <= 2'b00;
        @(posedge ref_clk);
        ack_req <= 1'b1;
        @(posedge ref_clk);
        ack_req <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("ack idle", PEER.seen[1], 2);
        chk("lone", n_err, 0);
        $display("test pairs done");
        final_report;
    end
endmodule
`default_nettype wire
